/* File: design/fes_pkg.sv */
// Purpose: shared constants and carriers for the flash erase/program sequencer
// Assumes: 16-bit processor address, 8-bit data, one bus clock
// Notes: control register bit positions follow the flash control register layout
package fes_pkg;
    // register map
    localparam logic [15:0] FES_CTRL_ADDR = 16'hfe07;
    localparam logic [15:0] FES_BPR_ADDR = 16'hff80;
    localparam logic [7:0] FES_CTRL_RST = 8'h00;
    // control bit positions
    localparam int FES_PGM_BIT = 0;
    localparam int FES_ERASE_BIT = 1;
    localparam int FES_MARGIN_BIT = 2;
    localparam int FES_HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam int FES_BLK_LSB = 4;
    localparam int FES_FDIV_LSB = 6;
    // array map
    localparam logic [15:0] FES_USER_LO = 16'ha000;
    localparam logic [15:0] FES_USER_HI = 16'hfdff;
    localparam logic [15:0] FES_VEC_LO = 16'hffea;
    localparam logic [15:0] FES_BPR_HI = 16'hff81;
    // protection starts, one per protection bit
    localparam logic [15:0] FES_PROT3 = 16'hf000;
    localparam logic [15:0] FES_PROT2 = 16'he000;
    localparam logic [15:0] FES_PROT1 = 16'hc000;
    localparam logic [15:0] FES_PROT0 = 16'ha000;
    // margin read stretch
    localparam logic [3:0] FES_STRETCH_CYC = 4'h8;
    localparam int FES_PAGE_BYTES = 8;

    typedef enum logic [2:0] {
        FES_ER_FULL,
        FES_ER_UPPER,
        FES_ER_LOWER,
        FES_ER_EIGHT_ROW,
        FES_ER_ROW,
        FES_ER_NONE
    } fes_region_t;

    // request toward the array macro
    typedef struct packed {
        logic erase_go;
        logic program_go;
        logic [15:0] erase_lo;
        logic [15:0] erase_hi;
        logic [15:0] page_base;
    } fes_array_cmd_t;
endpackage

/* File: design/fes_sequencer.sv */
// Purpose: flash erase / smart page program / margin read sequencer
// Assumes: register port with one-cycle read latency, array reads answered in place
// Notes: array storage itself is out of scope; array data comes in on arr_rdata_i
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module fes_sequencer
    import fes_pkg::*;
#(
    parameter int STRETCH = int'(FES_STRETCH_CYC)
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic rd_wait_o,
    input wire logic test_voltage_level_i,
    input wire logic [7:0] arr_rdata_i,
    output fes_array_cmd_t arr_cmd_o,
    output logic [63:0] page_data_o,
    output logic high_voltage_o,
    output logic margin_o,
    output logic pump_clk_en_o
);

    // all state of the block in one record
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] prot;
        logic prot_read;
        logic addr_latched;
        logic [15:0] lat_addr;
        logic [7:0] page_wmask;
        logic [63:0] page_data;
        logic [3:0] stretch_cnt;
        logic rd_wait; // registered copy of the stretch busy flag
        logic [1:0] pump_cnt;
        logic pump_en;
        logic pump_out; // registered pump enable, gated by high voltage
        logic [7:0] rdata;
        logic tv_s1;
        logic tv_s2;
        fes_array_cmd_t cmd;
    } fes_state_t;

    fes_state_t st_ff;
    fes_state_t nxt_st;

    // protection check, used for erase latch and program latch
    function automatic logic fes_protected(input logic [15:0] a, input logic [3:0] p, input logic bypass);
        logic hit;
        hit = 1'b0;
        if (!bypass) begin
            if (p[3] && a >= FES_PROT3) hit = 1'b1;
            if (p[2] && a >= FES_PROT2) hit = 1'b1;
            if (p[1] && a >= FES_PROT1) hit = 1'b1;
            if (p[0] && a >= FES_PROT0) hit = 1'b1;
        end
        return hit;
    endfunction

    // array selection test: user memory, vectors, or protection bytes
    function automatic logic fes_in_array(input logic [15:0] a);
        return (a >= FES_USER_LO && a <= FES_USER_HI) || (a >= FES_VEC_LO) ||
               (a >= FES_BPR_ADDR && a <= FES_BPR_HI);
    endfunction

    logic [7:0] ctl;
    logic in_arr;
    logic prot_hit;
    logic bypass;
    fes_region_t region;
    logic [15:0] er_lo;
    logic [15:0] er_hi;
    logic [2:0] pidx;
    logic [1:0] div_max;

    assign ctl = st_ff.ctrl;
    assign bypass = st_ff.tv_s2;
    assign in_arr = fes_in_array(addr_i);
    assign prot_hit = fes_protected(addr_i, st_ff.prot, bypass);
    assign pidx = addr_i[2:0];

    // region and erase range from the size select and write address
    always_comb begin
        region = FES_ER_NONE;
        er_lo = 16'h0000;
        er_hi = 16'h0000;
        unique case (ctl[FES_BLK_LSB +: 2])
            2'b00: begin
                region = FES_ER_FULL;
                er_lo = FES_USER_LO;
                er_hi = 16'hffff;
            end
            2'b01: begin
                if (addr_i[15:14] == 2'b11) begin
                    region = FES_ER_UPPER;
                    er_lo = FES_PROT1;
                    er_hi = 16'hffff;
                end else if (addr_i[15:14] == 2'b10) begin
                    region = FES_ER_LOWER;
                    er_lo = FES_USER_LO;
                    er_hi = 16'hbfff;
                end
            end
            2'b10: begin
                region = FES_ER_EIGHT_ROW;
                er_lo = {addr_i[15:9], 9'h000};
                er_hi = {addr_i[15:9], 9'h1ff};
            end
            2'b11: begin
                region = FES_ER_ROW;
                er_lo = {addr_i[15:6], 6'h00};
                er_hi = {addr_i[15:6], 6'h3f};
            end
        endcase
    end

    // pump divider terminal count
    always_comb begin
        unique case (ctl[FES_FDIV_LSB +: 2])
            2'b00: div_max = 2'd0;
            2'b11: div_max = 2'd3;
            default: div_max = 2'd1;
        endcase
    end

    // next-state logic
    always_comb begin
        logic [7:0] w;
        logic sets_both;
        w = wdata_i;
        sets_both = 1'b0;
        nxt_st = st_ff;
        nxt_st.tv_s1 = test_voltage_level_i;
        nxt_st.tv_s2 = st_ff.tv_s1;
        nxt_st.cmd.erase_go = 1'b0;
        nxt_st.cmd.program_go = 1'b0;
        nxt_st.rdata = 8'h00;
        // pump clock enable pulses
        if (st_ff.pump_cnt >= div_max) begin
            nxt_st.pump_cnt = 2'd0;
            nxt_st.pump_en = 1'b1;
        end else begin
            nxt_st.pump_cnt = st_ff.pump_cnt + 2'd1;
            nxt_st.pump_en = 1'b0;
        end
        // margin stretch counts down; watchdog lives elsewhere and keeps going
        if (st_ff.stretch_cnt != 4'h0) begin
            nxt_st.stretch_cnt = st_ff.stretch_cnt - 4'h1;
        end
        // control register write
        if (wr_i && addr_i == FES_CTRL_ADDR) begin
            // interlock: refuse setting one mode while the other is on or both at once
            sets_both = w[FES_PGM_BIT] && w[FES_ERASE_BIT];
            if (sets_both || (w[FES_PGM_BIT] && ctl[FES_ERASE_BIT]) ) w[FES_PGM_BIT] = 1'b0;
            if (sets_both || (w[FES_ERASE_BIT] && ctl[FES_PGM_BIT])) w[FES_ERASE_BIT] = 1'b0;
            // high voltage only with a mode, protection read and address latched
            if (!((w[FES_PGM_BIT] || w[FES_ERASE_BIT]) && st_ff.prot_read && st_ff.addr_latched)) begin
                w[FES_HIGH_VOLTAGE_ENABLE_BIT] = 1'b0;
            end
            if (w[FES_HIGH_VOLTAGE_ENABLE_BIT] || ctl[FES_HIGH_VOLTAGE_ENABLE_BIT]) w[FES_MARGIN_BIT] = 1'b0;
            // margin only while program mode is set or margin is already on
            if (!ctl[FES_PGM_BIT] && !ctl[FES_MARGIN_BIT]) w[FES_MARGIN_BIT] = 1'b0;
            // pulse edges toward the array macro
            if (w[FES_HIGH_VOLTAGE_ENABLE_BIT] && !ctl[FES_HIGH_VOLTAGE_ENABLE_BIT]) begin
                nxt_st.cmd.erase_go = w[FES_ERASE_BIT];
                nxt_st.cmd.program_go = w[FES_PGM_BIT];
            end
            // leaving a mode releases the latches
            if (!w[FES_PGM_BIT] && !w[FES_ERASE_BIT]) begin
                nxt_st.addr_latched = 1'b0;
                nxt_st.prot_read = 1'b0;
                nxt_st.page_wmask = 8'h00;
            end
            nxt_st.ctrl = w;
        end else if (wr_i && in_arr && !st_ff.addr_latched) begin
            // array write: erase address latch, or program page byte load
            if (ctl[FES_ERASE_BIT] && st_ff.prot_read) begin
                if (prot_hit || region == FES_ER_NONE) begin
                    nxt_st.ctrl[FES_ERASE_BIT] = 1'b0;
                end else begin
                    nxt_st.addr_latched = 1'b1;
                    nxt_st.lat_addr = addr_i;
                    nxt_st.cmd.erase_lo = er_lo;
                    nxt_st.cmd.erase_hi = er_hi;
                end
            end else if (ctl[FES_PGM_BIT] && st_ff.prot_read) begin
                if (prot_hit) begin
                    nxt_st.ctrl[FES_PGM_BIT] = 1'b0;
                end else if (st_ff.page_wmask == 8'h00 ||
                             addr_i[15:3] == st_ff.lat_addr[15:3]) begin
                    nxt_st.lat_addr = {addr_i[15:3], 3'b000};
                    nxt_st.cmd.page_base = {addr_i[15:3], 3'b000};
                    nxt_st.page_data[pidx*8 +: 8] = wdata_i;
                    nxt_st.page_wmask[pidx] = 1'b1;
                    if ((st_ff.page_wmask | (8'h01 << pidx)) == 8'hff) nxt_st.addr_latched = 1'b1;
                end
            end
        end
        // protection byte read latches the protection bits
        if (rd_i && addr_i == FES_BPR_ADDR) begin
            nxt_st.prot = arr_rdata_i[3:0];
            nxt_st.prot_read = ctl[FES_PGM_BIT] || ctl[FES_ERASE_BIT];
        end
        // read data path
        if (rd_i) begin
            if (addr_i == FES_CTRL_ADDR) begin
                nxt_st.rdata = ctl;
            end else begin
                nxt_st.rdata = arr_rdata_i;
                if (in_arr && ctl[FES_MARGIN_BIT]) nxt_st.stretch_cnt = 4'(STRETCH);
            end
        end
        // flags decoded from the next state, so every port leaves a flip-flop with no extra delay
        nxt_st.rd_wait = nxt_st.stretch_cnt != 4'h0;
        nxt_st.pump_out = nxt_st.pump_en & nxt_st.ctrl[FES_HIGH_VOLTAGE_ENABLE_BIT];
    end

    // state register with synchronous reset and clock enable
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.ctrl <= FES_CTRL_RST;
        end else if (clk_en_i) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign rd_wait_o = st_ff.rd_wait;
    assign arr_cmd_o = st_ff.cmd;
    assign page_data_o = st_ff.page_data;
    assign high_voltage_o = st_ff.ctrl[FES_HIGH_VOLTAGE_ENABLE_BIT];
    assign margin_o = st_ff.ctrl[FES_MARGIN_BIT];
    assign pump_clk_en_o = st_ff.pump_out;

    // both modes never stand together
    property p_interlock;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(st_ff.ctrl[FES_PGM_BIT] && st_ff.ctrl[FES_ERASE_BIT]);
    endproperty
    a_interlock: assert property (p_interlock) else $error("program and erase both set");

    // margin and high voltage never stand together
    property p_margin_hv;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(margin_o && high_voltage_o);
    endproperty
    a_margin_hv: assert property (p_margin_hv) else $error("margin with high voltage");

    // high voltage rises only with a mode and a protection read
    property p_hv_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(high_voltage_o) |-> $past(st_ff.prot_read) && (ctl[FES_PGM_BIT] || ctl[FES_ERASE_BIT]);
    endproperty
    a_hv_gate: assert property (p_hv_gate) else $error("high voltage without sequence");

    // margin array read raises wait for eight cycles
    property p_stretch;
        @(posedge ref_clk_i) disable iff (rst_i || !clk_en_i)
        (clk_en_i && rd_i && in_arr && margin_o && addr_i != FES_CTRL_ADDR) |=> rd_wait_o[*8];
    endproperty
    a_stretch: assert property (p_stretch) else $error("margin stretch too short");

    // erase row range is 64 aligned bytes
    property p_row;
        @(posedge ref_clk_i) disable iff (rst_i)
        (region == FES_ER_ROW) |-> (er_hi - er_lo == 16'h003f) && (er_lo[5:0] == 6'h00)
            && (addr_i >= er_lo) && (addr_i <= er_hi);
    endproperty
    a_row: assert property (p_row) else $error("row range wrong");

    // eight-row block is 512 aligned bytes
    property p_eight;
        @(posedge ref_clk_i) disable iff (rst_i)
        (region == FES_ER_EIGHT_ROW) |-> (er_hi - er_lo == 16'h01ff) && (er_lo[8:0] == 9'h000)
            && (addr_i >= er_lo) && (addr_i <= er_hi);
    endproperty
    a_eight: assert property (p_eight) else $error("eight-row range wrong");

    // latched page base is page aligned
    property p_page;
        @(posedge ref_clk_i) disable iff (rst_i)
        arr_cmd_o.page_base[2:0] == 3'b000;
    endproperty
    a_page: assert property (p_page) else $error("page base misaligned");

    // a protected latch write drops the erase mode next cycle
    property p_prot;
        @(posedge ref_clk_i) disable iff (rst_i)
        (clk_en_i && wr_i && in_arr && addr_i != FES_CTRL_ADDR && ctl[FES_ERASE_BIT] && st_ff.prot_read
         && !st_ff.addr_latched && prot_hit) |=> !st_ff.ctrl[FES_ERASE_BIT];
    endproperty
    a_prot: assert property (p_prot) else $error("protected erase not blocked");

endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the flash erase/program sequencer
// Assumes: register port with read data one cycle after the strobe; the bench plays the array
// Notes: array read data is driven beside each read strobe and scrambled once the read is over
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fes_pkg::*;
    localparam int STR = 8; // margin stretch length handed to the design
    logic ref_clk_i = 1'b0; // bus clock, 100 MHz
    logic rst_i = 1'b1; // synchronous reset, held for 8 cycles
    logic [15:0] addr_i = 16'h0000; // bus address
    logic [7:0] wdata_i = 8'h00; // bus write data
    logic wr_i = 1'b0; // write strobe
    logic rd_i = 1'b0; // read strobe
    logic test_voltage_level = 1'b0; // test voltage on the interrupt pin
    logic [7:0] arr_rdata_i = 8'h00; // array byte played by the bench
    logic [7:0] rdata_o;
    logic rd_wait_o;
    logic high_voltage_o;
    logic margin_o;
    logic pump_clk_en_o;
    fes_array_cmd_t arr_cmd_o;
    logic [63:0] page_data_o;
    int n_mismatch = 0; // failed comparisons
    int check_count = 0; // comparisons made
    logic [7:0] r; // scratch read value
    logic [63:0] pd; // expected page contents
    int n; // scratch cycle counter
    logic clk_en = 1'b1; // clock enable, dropped once to check that state freezes

    fes_sequencer #(.STRETCH(STR)) dut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .rd_wait_o(rd_wait_o),
        .test_voltage_level_i(test_voltage_level),
        .arr_rdata_i(arr_rdata_i),
        .arr_cmd_o(arr_cmd_o),
        .page_data_o(page_data_o),
        .high_voltage_o(high_voltage_o),
        .margin_o(margin_o),
        .pump_clk_en_o(pump_clk_en_o)
    );

    // free-running bus clock
    always #5 ref_clk_i = ~ref_clk_i;

    // single comparison point, counts every call
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write; returns just after the edge that took it, so outputs have settled
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // one-cycle read; array byte stands only beside the strobe, then goes to its inverse
    task automatic rd(input logic [15:0] a, input logic [7:0] arr, output logic [7:0] d);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        arr_rdata_i <= arr;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        arr_rdata_i <= ~arr;
        #1;
        d = rdata_o;
    endtask

    // full erase set-up for one size/divider pair, pulse, pump count and tear-down
    task automatic do_erase(input logic [1:0] sz, input logic [1:0] dv, input logic [15:0] a,
            input logic [15:0] lo, input logic [15:0] hi, input int np);
        logic [7:0] c;
        logic [7:0] q;
        int k;
        c = {dv, sz, 4'h2};
        wr(FES_CTRL_ADDR, c);
        rd(FES_BPR_ADDR, 8'h00, q);
        wr(a, 8'h5a);
        // a later array write must not move the latched address
        wr(a ^ 16'h0040, 8'h00);
        wr(FES_CTRL_ADDR, c | 8'h08);
        chk(arr_cmd_o.erase_go, 1'b1);
        chk(high_voltage_o, 1'b1);
        chk(arr_cmd_o.erase_lo, lo);
        chk(arr_cmd_o.erase_hi, hi);
        rd(FES_CTRL_ADDR, 8'h00, q);
        chk(q, c | 8'h08);
        chk(arr_cmd_o.erase_go, 1'b0);
        k = 0;
        // pump enables seen over eight bus cycles give the divide ratio
        repeat (8) begin
            @(posedge ref_clk_i);
            #1;
            if (pump_clk_en_o === 1'b1) k++;
        end
        chk(k, np);
        wr(FES_CTRL_ADDR, c);
        chk(high_voltage_o, 1'b0);
        chk(pump_clk_en_o, 1'b0);
        wr(FES_CTRL_ADDR, 8'h00);
    endtask

    // verdict; the one place the run ends
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs a little over a thousand cycles, well under 5000
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_mismatch++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(FES_CTRL_ADDR, 8'h00, r);
        chk(r, FES_CTRL_RST);
        chk(high_voltage_o, 1'b0);
        // both modes at once, from idle and from program mode
        wr(FES_CTRL_ADDR, 8'h03);
        rd(FES_CTRL_ADDR, 8'h00, r);
        chk(r[1] & r[0], 1'b0);
        wr(FES_CTRL_ADDR, 8'h01);
        wr(FES_CTRL_ADDR, 8'h03);
        rd(FES_CTRL_ADDR, 8'h00, r);
        chk(r[1] & r[0], 1'b0);
        wr(FES_CTRL_ADDR, 8'h00);
        // every size select and every divider code
        do_erase(2'b00, 2'b00, 16'ha123, 16'ha000, 16'hffff, 8);
        do_erase(2'b01, 2'b01, 16'hd123, 16'hc000, 16'hffff, 4);
        do_erase(2'b01, 2'b10, 16'hb123, 16'ha000, 16'hbfff, 4);
        do_erase(2'b10, 2'b11, 16'hfb10, 16'hfa00, 16'hfbff, 2);
        do_erase(2'b11, 2'b00, 16'hbc60, 16'hbc40, 16'hbc7f, 8);
        // high voltage without the protection read is refused
        wr(FES_CTRL_ADDR, 8'h02);
        wr(16'ha123, 8'h00);
        wr(FES_CTRL_ADDR, 8'h0a);
        chk(high_voltage_o, 1'b0);
        wr(FES_CTRL_ADDR, 8'h00);
        // whole array protected: the latching write kills the erase
        wr(FES_CTRL_ADDR, 8'h02);
        rd(FES_BPR_ADDR, 8'h01, r);
        wr(16'ha123, 8'h00);
        rd(FES_CTRL_ADDR, 8'h00, r);
        chk(r, 8'h00);
        wr(FES_CTRL_ADDR, 8'h0a);
        chk(high_voltage_o, 1'b0);
        // same again with the test voltage present: protection bypassed
        @(posedge ref_clk_i);
        test_voltage_level <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        wr(FES_CTRL_ADDR, 8'h02);
        rd(FES_BPR_ADDR, 8'h01, r);
        wr(16'ha123, 8'h00);
        rd(FES_CTRL_ADDR, 8'h00, r);
        chk(r, 8'h02);
        wr(FES_CTRL_ADDR, 8'h0a);
        chk(high_voltage_o, 1'b1);
        wr(FES_CTRL_ADDR, 8'h02);
        wr(FES_CTRL_ADDR, 8'h00);
        @(posedge ref_clk_i);
        test_voltage_level <= 1'b0;
        // page program on the eight-byte page at a108, the second page of its row
        wr(FES_CTRL_ADDR, 8'h01);
        rd(FES_BPR_ADDR, 8'h00, r);
        for (int i = 0; i < FES_PAGE_BYTES; i++) begin
            pd[8*i +: 8] = 8'(8'h11 * (i + 1));
            wr(16'ha108 + 16'(i), pd[8*i +: 8]);
        end
        chk(page_data_o, pd);
        chk(arr_cmd_o.page_base, 16'ha108);
        wr(FES_CTRL_ADDR, 8'h09);
        chk(arr_cmd_o.program_go, 1'b1);
        chk(high_voltage_o, 1'b1);
        // margin asked for while high voltage is on must not stick
        wr(FES_CTRL_ADDR, 8'h0d);
        chk(margin_o, 1'b0);
        wr(FES_CTRL_ADDR, 8'h01);
        wr(FES_CTRL_ADDR, 8'h05);
        chk(margin_o, 1'b1);
        wr(FES_CTRL_ADDR, 8'h04);
        // margin read of one page byte: compare the data, count the stretch cycles
        rd(16'ha108, pd[7:0], r);
        chk(r, pd[7:0]);
        n = 0;
        repeat (STR + 4) begin
            if (rd_wait_o === 1'b1) n++;
            @(posedge ref_clk_i);
            #1;
        end
        chk(n, STR);
        wr(FES_CTRL_ADDR, 8'h00);
        chk(margin_o, 1'b0);
        // dummy reads after the algorithm; ordinary reads are never stretched
        repeat (500) rd(16'ha108, pd[7:0], r);
        chk(r, pd[7:0]);
        chk(rd_wait_o, 1'b0);
        // a write while the clock enable is low must leave no trace
        @(posedge ref_clk_i);
        clk_en <= 1'b0;
        wr(FES_CTRL_ADDR, 8'h02);
        @(posedge ref_clk_i);
        clk_en <= 1'b1;
        rd(FES_CTRL_ADDR, 8'h00, r);
        chk(r, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
